// file: core/fault_recovery_pkg.sv
// constants, register map and state codes for the fault recovery block
// assumes a single 100 MHz system clock
package fault_recovery_pkg;
	localparam int          CLK_HZ         = 100_000_000;
	localparam int          TENTH_MS       = 100;
	localparam int          TENTH_CYCLES   = CLK_HZ / 1000 * TENTH_MS;
	localparam int          MIN_LONG_S     = 10;
	localparam logic [15:0] MIN_LONG_TENTH = 16'(MIN_LONG_S * 10);
	localparam int          QUIET_MIN      = 5;
	localparam logic [15:0] QUIET_TENTH    = 16'(QUIET_MIN * 60 * 10);
	localparam int          HIST_DEPTH     = 10;
	localparam logic [2:0]  LIMIT_NONE     = 3'h0;
	localparam logic [2:0]  LIMIT_INF      = 3'h6;
	localparam logic [2:0]  LIMIT_RST      = 3'h5;
	localparam logic [15:0] DELAY_RST      = 16'h0032;
	localparam logic [3:0]  PRIO_MAX_HELD  = 4'h3;
	localparam logic [6:0]  IDX_LIMIT      = 7'h30;
	localparam logic [6:0]  IDX_DELAY      = 7'h31;
	localparam logic [6:0]  IDX_CODE0      = 7'h32;
	localparam logic [6:0]  IDX_STAMP0     = 7'h3C;
	localparam logic [6:0]  IDX_CTRL       = 7'h50;
	localparam logic [6:0]  IDX_STATUS     = 7'h51;
	localparam int          CTRL_MAN_BIT   = 0;
	localparam int          STAT_TRIP_BIT  = 0;
	localparam int          STAT_CNT_LSB   = 4;
	localparam int          STAT_CODE_LSB  = 8;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_TRIP = 2'b10
	} trip_state_t;
endpackage

// file: core/fault_recovery.sv
// fault auto recovery, retry counting and ten-deep fault history
// assumes fault and calendar inputs come from logic on mclk
`timescale 1ns/100ps
module fault_recovery
	import fault_recovery_pkg::*;
#(
	parameter int TENTH_COUNT = TENTH_CYCLES
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        srst,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [8:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [3:0]  wb_sel_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// fault event
	input  wire logic        fault_valid,
	input  wire logic [7:0]  fault_code,
	input  wire logic [3:0]  fault_prio,
	input  wire logic        fault_long_min,
	input  wire logic        manual_reset,
	// calendar
	input  wire logic [23:0] cal_date,
	input  wire logic [23:0] cal_time,
	// status
	output logic             tripped,
	output logic             auto_clear,
	output logic      [2:0]  retry_count
);
	trip_state_t state_q;
	logic [2:0]  limit_q;
	logic [15:0] delay_q;
	logic [2:0]  count_q;
	logic [7:0]  last_code_q;
	logic        have_last_q;
	logic        auto_ok_q;
	logic        long_min_q;
	logic [3:0]  prio_q;
	logic [31:0] pre_q;
	logic        tick_q;
	logic [15:0] tenths_q;
	logic [15:0] quiet_q;
	logic [7:0]  code_q [HIST_DEPTH];
	logic [23:0] date_q [HIST_DEPTH];
	logic [23:0] time_q [HIST_DEPTH];
	logic        man_wr;
	logic        man;
	logic        take;
	logic        same;
	logic [2:0]  cnt_new;
	logic [15:0] eff_delay;
	logic        clr_now;
	logic        req;
	logic [6:0]  idx;

	function automatic logic [15:0] max16(input logic [15:0] a, input logic [15:0] b);
		return (a > b) ? a : b;
	endfunction

	assign req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign idx  = wb_adr_i[8:2];
	assign man_wr = req && wb_we_i && (idx == IDX_CTRL) && wb_sel_i[0] && wb_dat_i[CTRL_MAN_BIT];
	assign man  = manual_reset || man_wr;
	assign take = fault_valid && (state_q == ST_IDLE);
	assign same = have_last_q && (fault_code == last_code_q);
	// a new code or limit six gives zero, otherwise count up while below limit, else hold
	assign cnt_new = (!same || limit_q == LIMIT_INF) ? 3'h0 :
		((count_q < limit_q) ? 3'(count_q + 3'h1) : count_q);
	assign eff_delay = long_min_q ? max16(delay_q, MIN_LONG_TENTH) : delay_q;
	assign clr_now = (state_q == ST_TRIP) && auto_ok_q && tick_q && (tenths_q >= eff_delay)
		&& (limit_q != LIMIT_NONE);

	// tenth-second prescaler
	always_ff @(posedge mclk) begin
		if (srst) begin
			pre_q  <= 32'h0;
			tick_q <= 1'b0;
		end else if (pre_q == 32'(TENTH_COUNT - 1)) begin
			pre_q  <= 32'h0;
			tick_q <= 1'b1;
		end else begin
			pre_q  <= pre_q + 32'h1;
			tick_q <= 1'b0;
		end
	end

	// elapsed tenths since fault
	always_ff @(posedge mclk) begin
		if (srst || take) begin
			tenths_q <= 16'h0;
		end else if (tick_q && tenths_q != 16'hFFFF) begin
			tenths_q <= tenths_q + 16'h1;
		end
	end

	// fault-free time
	always_ff @(posedge mclk) begin
		if (srst || take) begin
			quiet_q <= 16'h0;
		end else if (tick_q && quiet_q < QUIET_TENTH) begin
			quiet_q <= quiet_q + 16'h1;
		end
	end

	// trip state
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q    <= ST_IDLE;
			auto_clear <= 1'b0;
		end else begin
			auto_clear <= 1'b0;
			unique case (state_q)
				ST_IDLE: begin
					if (take) begin
						state_q <= ST_TRIP;
					end
				end
				ST_TRIP: begin
					if (man) begin
						state_q <= ST_IDLE;
					end else if (clr_now) begin
						state_q    <= ST_IDLE;
						auto_clear <= 1'b1;
					end
				end
			endcase
		end
	end

	// retry counter and eligibility
	always_ff @(posedge mclk) begin
		if (srst) begin
			count_q     <= 3'h0;
			last_code_q <= 8'h00;
			have_last_q <= 1'b0;
			auto_ok_q   <= 1'b0;
			long_min_q  <= 1'b0;
			prio_q      <= 4'h0;
		end else begin
			if (take) begin
				last_code_q <= fault_code;
				have_last_q <= 1'b1;
				long_min_q  <= fault_long_min;
				prio_q      <= fault_prio;
				auto_ok_q   <= (limit_q != LIMIT_NONE) && (fault_prio > PRIO_MAX_HELD)
					&& (cnt_new < limit_q);
			end
			if (man) begin
				count_q <= 3'h0;
			end else if (take) begin
				count_q <= cnt_new;
			end else if (limit_q == LIMIT_INF) begin
				count_q <= 3'h0;
			end else if (count_q < limit_q && quiet_q >= QUIET_TENTH) begin
				count_q <= 3'h0;
			end
		end
	end

	// history shift
	always_ff @(posedge mclk) begin
		if (srst) begin
			for (int i = 0; i < HIST_DEPTH; i++) begin
				code_q[i] <= 8'h00;
				date_q[i] <= 24'h000000;
				time_q[i] <= 24'h000000;
			end
		end else if (take) begin
			code_q[0] <= fault_code;
			date_q[0] <= cal_date;
			time_q[0] <= cal_time;
			for (int i = 1; i < HIST_DEPTH; i++) begin
				code_q[i] <= code_q[i-1];
				date_q[i] <= date_q[i-1];
				time_q[i] <= time_q[i-1];
			end
		end
	end

	// settings registers
	always_ff @(posedge mclk) begin
		if (srst) begin
			limit_q <= LIMIT_RST;
			delay_q <= DELAY_RST;
		end else if (req && wb_we_i) begin
			if (idx == IDX_LIMIT && wb_sel_i[0] && wb_dat_i[2:0] <= LIMIT_INF) begin
				limit_q <= wb_dat_i[2:0];
			end
			if (idx == IDX_DELAY) begin
				if (wb_sel_i[0]) begin
					delay_q[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					delay_q[15:8] <= wb_dat_i[15:8];
				end
			end
		end
	end

	// bus answer, history is read only
	always_ff @(posedge mclk) begin
		if (srst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= 32'h0;
			if (req && !wb_we_i) begin
				if (idx == IDX_LIMIT) begin
					wb_dat_o <= {29'h0, limit_q};
				end else if (idx == IDX_DELAY) begin
					wb_dat_o <= {16'h0, delay_q};
				end else if (idx >= IDX_CODE0 && idx < IDX_STAMP0) begin
					wb_dat_o <= {24'h0, code_q[4'(idx - IDX_CODE0)]};
				end else if (idx >= IDX_STAMP0 && idx < 7'(IDX_STAMP0 + 7'(2 * HIST_DEPTH))) begin
					wb_dat_o <= idx[0] ? {8'h0, time_q[4'((idx - IDX_STAMP0) >> 1)]}
						: {8'h0, date_q[4'((idx - IDX_STAMP0) >> 1)]};
				end else if (idx == IDX_STATUS) begin
					wb_dat_o <= {16'h0, last_code_q, 1'b0, count_q, 3'h0, (state_q == ST_TRIP)};
				end
			end
		end
	end

	// status outputs
	always_ff @(posedge mclk) begin
		if (srst) begin
			tripped     <= 1'b0;
			retry_count <= 3'h0;
		end else begin
			tripped     <= (state_q == ST_TRIP);
			retry_count <= count_q;
		end
	end

	sequence s_take_diff;
		take && !same;
	endsequence
	sequence s_take_same;
		take && same && limit_q != LIMIT_INF && count_q < limit_q && !man;
	endsequence
	sequence s_clear_due;
		state_q == ST_TRIP && auto_ok_q && tick_q && tenths_q >= eff_delay && limit_q != LIMIT_NONE && !man;
	endsequence

	property p_zero_limit;
		@(posedge mclk) disable iff (srst) auto_clear |-> $past(auto_ok_q) && $past(limit_q, 1) != LIMIT_NONE;
	endproperty
	a_zero_limit: assert property (p_zero_limit) else $error("auto clear with zero limit");
	property p_delay;
		@(posedge mclk) disable iff (srst) auto_clear |-> $past(tenths_q) >= $past(delay_q);
	endproperty
	a_delay: assert property (p_delay) else $error("auto clear before delay");
	property p_long_min;
		@(posedge mclk) disable iff (srst) (auto_clear && $past(long_min_q)) |-> $past(tenths_q) >= MIN_LONG_TENTH;
	endproperty
	a_long_min: assert property (p_long_min) else $error("auto clear before ten seconds");
	property p_diff;
		@(posedge mclk) disable iff (srst) (s_take_diff and !man) |=> count_q == 3'h0;
	endproperty
	a_diff: assert property (p_diff) else $error("counter not zeroed on new code");
	property p_same;
		@(posedge mclk) disable iff (srst) s_take_same |=> count_q == $past(count_q) + 3'h1;
	endproperty
	a_same: assert property (p_same) else $error("counter not incremented");
	property p_block;
		@(posedge mclk) disable iff (srst) (take && same && count_q == limit_q && limit_q != LIMIT_INF) |=> !auto_ok_q;
	endproperty
	a_block: assert property (p_block) else $error("auto clear armed at limit");
	property p_prio;
		@(posedge mclk) disable iff (srst) auto_clear |-> $past(prio_q) > PRIO_MAX_HELD;
	endproperty
	a_prio: assert property (p_prio) else $error("auto clear of held priority");
	property p_manual;
		@(posedge mclk) disable iff (srst) man |=> count_q == 3'h0;
	endproperty
	a_manual: assert property (p_manual) else $error("manual reset left counter");
	property p_inf;
		@(posedge mclk) disable iff (srst) (limit_q == LIMIT_INF)[*2] |-> count_q == 3'h0;
	endproperty
	a_inf: assert property (p_inf) else $error("counter nonzero in unlimited mode");
	property p_shift;
		@(posedge mclk) disable iff (srst) take |=> code_q[0] == $past(fault_code) && code_q[9] == $past(code_q[8])
			&& date_q[0] == $past(cal_date) && time_q[1] == $past(time_q[0]);
	endproperty
	a_shift: assert property (p_shift) else $error("history shift wrong");

	property p_hist_deep;
		@(posedge mclk) disable iff (srst) take |=> code_q[5] == $past(code_q[4])
			&& date_q[9] == $past(date_q[8]) && time_q[9] == $past(time_q[8]);
	endproperty
	a_hist_deep: assert property (p_hist_deep) else $error("deep history shift wrong");
	property p_hist_hold;
		@(posedge mclk) disable iff (srst) !take |=> $stable(code_q[0]) && $stable(code_q[9]);
	endproperty
	a_hist_hold: assert property (p_hist_hold) else $error("history moved without fault");
	property p_stamp;
		@(posedge mclk) disable iff (srst) take |=> time_q[0] == $past(cal_time) && date_q[0] == $past(cal_date);
	endproperty
	a_stamp: assert property (p_stamp) else $error("stamp not from calendar");
	property p_ro;
		@(posedge mclk) disable iff (srst) (req && wb_we_i && !take && idx >= IDX_CODE0 && idx < IDX_CTRL)
			|=> $stable(code_q[0]) && $stable(date_q[0]) && $stable(time_q[9]);
	endproperty
	a_ro: assert property (p_ro) else $error("history written by bus");
	property p_quiet;
		@(posedge mclk) disable iff (srst) (!take && !man && limit_q != LIMIT_INF && count_q < limit_q
			&& quiet_q >= QUIET_TENTH) |=> count_q == 3'h0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("counter kept after quiet time");
	property p_tick;
		@(posedge mclk) disable iff (srst) tick_q |-> $past(pre_q) == 32'(TENTH_COUNT - 1);
	endproperty
	a_tick: assert property (p_tick) else $error("tick off prescaler end");
	property p_tenths;
		@(posedge mclk) disable iff (srst) (tick_q && !take && tenths_q != 16'hFFFF) |=> tenths_q == $past(tenths_q) + 16'h1;
	endproperty
	a_tenths: assert property (p_tenths) else $error("tenths not counted");
	property p_clear;
		@(posedge mclk) disable iff (srst) s_clear_due |=> auto_clear && state_q == ST_IDLE;
	endproperty
	a_clear: assert property (p_clear) else $error("due clear not made");
	property p_none;
		@(posedge mclk) disable iff (srst) (limit_q == LIMIT_NONE) |=> !auto_clear;
	endproperty
	a_none: assert property (p_none) else $error("auto clear while limit zero");
	property p_held;
		@(posedge mclk) disable iff (srst) (take && fault_prio <= PRIO_MAX_HELD) |=> !auto_ok_q;
	endproperty
	a_held: assert property (p_held) else $error("held priority armed");
	property p_man_idle;
		@(posedge mclk) disable iff (srst) (man && state_q == ST_TRIP) |=> state_q == ST_IDLE;
	endproperty
	a_man_idle: assert property (p_man_idle) else $error("manual reset left trip");
	property p_ack;
		@(posedge mclk) disable iff (srst) req |=> wb_ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("request not acked");
	property p_ack_pulse;
		@(posedge mclk) disable iff (srst) wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_rd_zero;
		@(posedge mclk) disable iff (srst) (req && !wb_we_i && idx == IDX_CTRL) |=> wb_dat_o == 32'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("ctrl read not zero");
	property p_limit_keep;
		@(posedge mclk) disable iff (srst) (req && wb_we_i && idx == IDX_LIMIT && wb_dat_i[2:0] > LIMIT_INF) |=> $stable(limit_q);
	endproperty
	a_limit_keep: assert property (p_limit_keep) else $error("illegal limit taken");
	property p_trip_out;
		@(posedge mclk) disable iff (srst) tripped == ($past(state_q) == ST_TRIP);
	endproperty
	a_trip_out: assert property (p_trip_out) else $error("tripped output wrong");
	property p_count_out;
		@(posedge mclk) disable iff (srst) retry_count == $past(count_q);
	endproperty
	a_count_out: assert property (p_count_out) else $error("retry count output wrong");
endmodule

// file: testbench/tb.sv
// self-checking bench for the fault recovery block
// assumes the design alone, with a ten-cycle tenth tick
`timescale 1ns/100ps
module tb
	import fault_recovery_pkg::*;
;
	localparam int TK = 10;
	logic        mclk, srst, cyc, stb, we, fv, fl, man, use_reg;
	logic [8:0]  adr;
	logic [31:0] wdat, rd;
	logic [3:0]  sel, prio;
	logic [7:0]  code;
	logic [23:0] dat_c, tim_c;
	wire logic [31:0] rdat;
	wire logic        ack, tripped, aclr;
	wire logic [2:0]  cnt;
	logic [7:0]  qc[$];
	logic [23:0] qd[$], qt[$];
	int          errors, comparisons;

	fault_recovery #(.TENTH_COUNT(TK)) i_dut (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack),
		.fault_valid(fv), .fault_code(code), .fault_prio(prio), .fault_long_min(fl), .manual_reset(man),
		.cal_date(dat_c), .cal_time(tim_c), .tripped(tripped), .auto_clear(aclr), .retry_count(cnt));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task summarize;
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	// one classic cycle, held until ack is sampled
	task wb(input logic w, input logic [6:0] idx, input logic [31:0] d);
		int n;
		@(posedge mclk);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= {idx, 2'b00};
		wdat <= d;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1) begin
			errors++;
			summarize;
		end
	endtask

	task rreg(input logic [6:0] idx, input logic [31:0] e);
		wb(1'b0, idx, 32'h0);
		chk(rd, e);
	endtask

	// one fault event, then either a timed clear or a manual reset
	task trip(input logic [7:0] c, input logic [3:0] p, input logic l, input logic x,
		input int lo, input int hi, input logic [2:0] ec);
		int n;
		@(posedge mclk);
		fv    <= 1'b1;
		code  <= c;
		prio  <= p;
		fl    <= l;
		dat_c <= dat_c + 24'h000101;
		tim_c <= tim_c + 24'h010203;
		@(posedge mclk);
		fv <= 1'b0;
		qc.push_front(c);
		qd.push_front(dat_c);
		qt.push_front(tim_c);
		n = 0;
		while (aclr !== 1'b1 && n < 1200) begin
			@(posedge mclk);
			n++;
		end
		chk(aclr, x);
		if (x && aclr !== 1'b1)
			summarize;
		if (x)
			chk(n >= lo && n <= hi, 1'b1);
		repeat (3) @(posedge mclk);
		chk(cnt, ec);
		if (!x) begin
			chk(tripped, 1'b1);
			rreg(IDX_STATUS, {16'h0, c, 1'b0, ec, 4'h1});
			if (use_reg) begin
				wb(1'b1, IDX_CTRL, 32'h1);
			end else begin
				@(posedge mclk);
				man <= 1'b1;
				@(posedge mclk);
				man <= 1'b0;
			end
			repeat (3) @(posedge mclk);
			chk(cnt, 3'h0);
			chk(tripped, 1'b0);
		end
	endtask

	initial begin
		srst = 1'b1;
		{cyc, stb, we, fv, fl, man} = 6'h00;
		use_reg = 1'b0;
		adr = 9'h000;
		wdat = 32'h0;
		sel = 4'hF;
		prio = 4'h0;
		code = 8'h00;
		dat_c = 24'h100000;
		tim_c = 24'h200000;
		errors = 0;
		comparisons = 0;
		repeat (6) @(posedge mclk);
		srst <= 1'b0;
		rreg(IDX_LIMIT, 32'(LIMIT_RST));
		rreg(IDX_DELAY, 32'(DELAY_RST));
		rreg(7'h7F, 32'h0);
		rreg(IDX_CTRL, 32'h0);
		wb(1'b1, IDX_CODE0, 32'hAA);
		rreg(IDX_CODE0, 32'h0);
		wb(1'b1, IDX_DELAY, 32'h2);
		rreg(IDX_DELAY, 32'h2);
		trip(8'h11, 4'h4, 1'b0, 1'b1, 2 * TK + 1, 3 * TK + 1, 3'h0);
		trip(8'h11, 4'h4, 1'b0, 1'b1, 2 * TK + 1, 3 * TK + 1, 3'h1);
		trip(8'h22, 4'h4, 1'b0, 1'b1, 2 * TK + 1, 3 * TK + 1, 3'h0);
		wb(1'b1, IDX_LIMIT, 32'h1);
		trip(8'h22, 4'h4, 1'b0, 1'b0, 0, 0, 3'h1);
		wb(1'b1, IDX_LIMIT, 32'h0);
		use_reg = 1'b1;
		trip(8'h33, 4'h4, 1'b0, 1'b0, 0, 0, 3'h0);
		use_reg = 1'b0;
		wb(1'b1, IDX_LIMIT, 32'h5);
		for (int p = 1; p <= 3; p++)
			trip(8'h44, 4'(p), 1'b0, 1'b0, 0, 0, (p == 1) ? 3'h0 : 3'h1);
		trip(8'h44, 4'h4, 1'b1, 1'b1, 100 * TK + 1, 101 * TK + 1, 3'h1);
		wb(1'b1, IDX_LIMIT, 32'h6);
		wb(1'b1, IDX_LIMIT, 32'h7);
		rreg(IDX_LIMIT, 32'h6);
		chk(cnt, 3'h0);
		trip(8'h66, 4'h4, 1'b0, 1'b1, 2 * TK + 1, 3 * TK + 1, 3'h0);
		trip(8'h66, 4'h4, 1'b0, 1'b1, 2 * TK + 1, 3 * TK + 1, 3'h0);
		wb(1'b1, IDX_LIMIT, 32'h5);
		trip(8'h66, 4'h4, 1'b0, 1'b1, 2 * TK + 1, 3 * TK + 1, 3'h1);
		wb(1'b1, IDX_LIMIT, 32'h1);
		trip(8'h66, 4'h4, 1'b0, 1'b0, 0, 0, 3'h1);
		wb(1'b1, IDX_LIMIT, 32'h5);
		trip(8'h66, 4'h4, 1'b0, 1'b1, 2 * TK + 1, 3 * TK + 1, 3'h1);
		repeat (int'(QUIET_TENTH) * TK - 1100) @(posedge mclk);
		chk(cnt, 3'h1);
		repeat (1200) @(posedge mclk);
		chk(cnt, 3'h0);
		for (int i = 0; i < HIST_DEPTH; i++) begin
			rreg(7'(IDX_CODE0 + i), 32'(qc[i]));
			rreg(7'(IDX_STAMP0 + 2 * i), 32'(qd[i]));
			rreg(7'(IDX_STAMP0 + 2 * i + 1), 32'(qt[i]));
		end
		summarize;
	end
endmodule
